// ### verilog/edge_pkg.sv
/* edge_pkg: constants and types shared by the edge enhancement filter.
   assumes: included before the filter module; no other dependencies. */
package edge_pkg;
  // flush and latency figures, in core clock cycles
  localparam int LINE_FLUSH_CYC = 19;
  localparam int LATENCY_CYC    = 19;
  // right-neighbour wait and the output buffer each take one cycle
  localparam int PIPE_STAGES    = LATENCY_CYC - 2;
  localparam int BUF_DEPTH      = 2;
  // frame size limits and sample widths
  localparam int MIN_DIM        = 32;
  localparam int MAX_DIM        = 7680;
  localparam int DIM_W          = $clog2(MAX_DIM + 1);
  localparam int DW_DEF         = 8;
  localparam int DW_LO          = 8;
  localparam int DW_HI          = 12;
  localparam int NCOMP          = 3;
  localparam int TAPS           = 9;
  // gains are unsigned with GAIN_FRAC fraction bits
  localparam int GAIN_W         = 8;
  localparam int GAIN_FRAC      = 4;

  typedef enum logic [1:0] {
    S_RUN    = 2'b00,
    S_LFLUSH = 2'b01,
    S_FFLUSH = 2'b10,
    S_TAIL   = 2'b11
  } fstate_t;

  typedef struct packed {
    logic last;
    logic user;
  } meta_t;
endpackage: edge_pkg

// ### verilog/edge_filter.sv
/* edge_filter: 3x3 sobel/laplacian edge enhancement on a YCbCr 4:4:4 video stream,
   with two line memories, a fixed-depth pipeline and a two-entry output buffer.
   assumes: upstream and downstream are AXI4-Stream video blocks on CLK_I;
   tuser marks the first pixel of a frame, tlast the last of a line. */
`timescale 1ns/10ps
// Contract
// - output pixel appears one scan line plus 19 cycles after its input.
// - exactly one output pixel per accepted input pixel; frame size kept.
// - without input, output valid stops once internal buffering drains.
// - with downstream stalled, input ready drops once buffering is full.
// - with input valid and output ready, one pixel in and out per cycle.
// - after each line's last pixel, input ready stays low 19 cycles.
// - after a frame's last line, input ready stays low about one line.
// - output combines sobel and laplacian responses with the original pixel.
// - each operator's contribution scaled by its own gain.
// - pixels are full YCbCr triplets on both ports.
// - sample width is 8, 10 or 12 bits, same at both ports.
// - frames from 32x32 up to 7680x7680 are handled.
// - build options give a bypass mode and a test pattern mode.
// - both ports follow stream video handshake and framing conventions.
// - inputs sampled at the rising clock edge; outputs change after it.
// - core advances only with clock enable high; synchronous reset.
module edge_filter #(
  parameter int DW         = edge_pkg::DW_DEF,
  parameter int MAX_COLS   = edge_pkg::MAX_DIM,
  parameter bit HAS_BYPASS = 1'b1,
  parameter bit HAS_TPG    = 1'b1
) (
  input  wire logic                             CLK_I,
  input  wire logic                             RST_I,
  input  wire logic                             CE_I,
  input  wire logic [edge_pkg::NCOMP*DW-1:0]    S_TDATA_I,
  input  wire logic                             S_TVALID_I,
  input  wire logic                             S_TLAST_I,
  input  wire logic                             S_TUSER_I,
  output logic                                  S_TREADY_O,
  output logic      [edge_pkg::NCOMP*DW-1:0]    M_TDATA_O,
  output logic                                  M_TVALID_O,
  output logic                                  M_TLAST_O,
  output logic                                  M_TUSER_O,
  input  wire logic                             M_TREADY_I,
  input  wire logic [edge_pkg::GAIN_W-1:0]      SOBEL_GAIN_I,
  input  wire logic [edge_pkg::GAIN_W-1:0]      LAPLACE_GAIN_I,
  input  wire logic                             BYPASS_I,
  input  wire logic                             TPG_I,
  input  wire logic [edge_pkg::DIM_W-1:0]       FRAME_ROWS_I
);
  import edge_pkg::*;

  localparam int PW   = NCOMP * DW;
  localparam int CVW  = 3 * PW;
  localparam int AW   = $clog2(MAX_COLS);
  localparam int YMAX = (1 << DW) - 1;
  localparam int LAST = PIPE_STAGES - 1;
  localparam int CNTW = $clog2(BUF_DEPTH + 1);
  localparam logic [DIM_W-1:0] ONE_D   = DIM_W'(1);
  localparam logic [DIM_W-1:0] FL_LAST = DIM_W'(LINE_FLUSH_CYC - 1);
  localparam logic [CNTW-1:0]  BUF_FULL = CNTW'(BUF_DEPTH);

  typedef logic [PW-1:0]  pix_t;
  typedef logic [CVW-1:0] colv_t;

  // refuse widths and line lengths the datapath cannot serve
  if (DW < DW_LO || DW > DW_HI || DW % 2 != 0 || MAX_COLS < MIN_DIM || MAX_COLS > MAX_DIM ||
      BUF_DEPTH != 2) begin : g_bad_cfg
    $error("edge_filter: unsupported width, line length or buffer depth");
  end

  // luma of row r (0 bottom, 1 middle, 2 top) in a column vector
  function automatic logic [DW-1:0] luma(input colv_t cv, input int r);
    luma = cv[r*PW +: DW];
  endfunction: luma

  // signed sobel magnitude and laplacian, each gained, added to centre and clamped
  function automatic logic [DW-1:0] enhance(input logic [TAPS*DW-1:0] w,
                                             input logic [GAIN_W-1:0]  gs,
                                             input logic [GAIN_W-1:0]  gl);
    int p [TAPS];
    int gx;
    int gy;
    int sob;
    int lap;
    int acc;
    for (int i = 0; i < TAPS; i++) begin
      p[i] = int'(w[i*DW +: DW]);
    end
    gx  = (p[2] + 2*p[5] + p[8]) - (p[0] + 2*p[3] + p[6]);
    gy  = (p[6] + 2*p[7] + p[8]) - (p[0] + 2*p[1] + p[2]);
    sob = (gx < 0 ? -gx : gx) + (gy < 0 ? -gy : gy);
    lap = 4*p[4] - p[1] - p[3] - p[5] - p[7];
    // sobel follows the laplacian sign so dark sides of an edge darken
    if (lap < 0) begin
      sob = -sob;
    end
    acc = p[4] + ((int'(gs) * sob + int'(gl) * lap) >>> GAIN_FRAC);
    if (acc < 0) begin
      enhance = '0;
    end else if (acc > YMAX) begin
      enhance = YMAX[DW-1:0];
    end else begin
      enhance = acc[DW-1:0];
    end
  endfunction: enhance

  fstate_t          state_r, state_nxt;
  logic [DIM_W-1:0] col_r, col_nxt, row_r, row_nxt, cols_r, cols_nxt, fl_r, fl_nxt;
  logic [DIM_W-1:0] cur_col, cur_row;
  colv_t            win0_r, win0_nxt, win1_r, win1_nxt, newc, left;
  pix_t             mem_a [MAX_COLS];
  pix_t             mem_b [MAX_COLS];
  pix_t             rd_a, rd_b, ctr, s0_pix;
  meta_t            s0_meta;
  logic             pipe_en, adv, in_fire, step_v, step_f, step, emit;
  logic             pv_r [PIPE_STAGES];
  logic             pv_nxt [PIPE_STAGES];
  pix_t             pd_r [PIPE_STAGES];
  pix_t             pd_nxt [PIPE_STAGES];
  meta_t            pm_r [PIPE_STAGES];
  meta_t            pm_nxt [PIPE_STAGES];
  pix_t             bd_r [BUF_DEPTH];
  pix_t             bd_nxt [BUF_DEPTH];
  meta_t            bm_r [BUF_DEPTH];
  meta_t            bm_nxt [BUF_DEPTH];
  logic             wp_r, wp_nxt, rp_r, rp_nxt, push, pop;
  logic [CNTW-1:0]  cnt_r, cnt_nxt;

  // the whole pipeline stalls only when its last word cannot enter a full buffer
  assign pipe_en    = !(pv_r[LAST] && cnt_r == BUF_FULL);
  assign adv        = CE_I && pipe_en;
  assign S_TREADY_O = adv && !RST_I && state_r == S_RUN;
  assign in_fire    = S_TVALID_I && S_TREADY_O;
  assign step_v     = adv && (state_r == S_LFLUSH || state_r == S_TAIL) && fl_r == '0;
  assign step_f     = adv && state_r == S_FFLUSH;
  assign step       = in_fire || step_v || step_f;

  // a tuser beat restarts the frame at row 0, column 0
  assign cur_col = (in_fire && S_TUSER_I) ? '0 : col_r;
  assign cur_row = (in_fire && S_TUSER_I) ? '0 : row_r;
  assign rd_a    = mem_a[cur_col[AW-1:0]];
  assign rd_b    = mem_b[cur_col[AW-1:0]];

  // new right column {top, middle, bottom}; edges replicate the nearest row or column
  always_comb begin
    newc = win1_r;
    if (in_fire) begin
      newc = {(cur_row == ONE_D) ? rd_a : rd_b, rd_a, S_TDATA_I};
    end else if (step_f) begin
      newc = {rd_b, rd_a, rd_a};
    end
  end

  assign left = (cur_col == ONE_D && !step_v) ? win1_r : win0_r;
  assign ctr  = win1_r[PW +: PW];

  // an output exists once a centre row and a right neighbour are known
  assign emit = (in_fire && cur_row != '0 && cur_col != '0) || (step_v && row_r != '0) ||
                (step_f && col_r != '0);

  // stage 0 word: enhanced luma, chroma passed, or one of the optional modes
  always_comb begin
    s0_pix = {ctr[PW-1:DW], enhance({luma(newc, 0), luma(win1_r, 0), luma(left, 0),
                                     luma(newc, 1), luma(win1_r, 1), luma(left, 1),
                                     luma(newc, 2), luma(win1_r, 2), luma(left, 2)},
                                    SOBEL_GAIN_I, LAPLACE_GAIN_I)};
    if (HAS_BYPASS && BYPASS_I) begin
      s0_pix = ctr;
    end
    if (HAS_TPG && TPG_I) begin
      s0_pix = {NCOMP{col_r[DW-1:0]}};
    end
    s0_meta.user = in_fire && cur_row == ONE_D && cur_col == ONE_D;
    s0_meta.last = step_v;
  end

  // framing: line flush after every tlast, then a flush row and a tail at frame end
  always_comb begin
    state_nxt = state_r;
    col_nxt   = col_r;
    row_nxt   = row_r;
    cols_nxt  = cols_r;
    fl_nxt    = fl_r;
    win0_nxt  = win0_r;
    win1_nxt  = win1_r;
    if (step) begin
      win0_nxt = win1_r;
      win1_nxt = newc;
    end
    case (state_r)
      S_RUN: begin
        if (in_fire) begin
          row_nxt = cur_row;
          col_nxt = cur_col + ONE_D;
          if (S_TLAST_I) begin
            cols_nxt  = cur_col + ONE_D;
            col_nxt   = '0;
            fl_nxt    = '0;
            state_nxt = S_LFLUSH;
          end
        end
      end
      S_LFLUSH, S_TAIL: begin
        if (adv) begin
          fl_nxt = fl_r + ONE_D;
          if (fl_r == FL_LAST) begin
            fl_nxt = '0;
            if (state_r == S_TAIL) begin
              state_nxt = S_RUN;
              row_nxt   = '0;
            end else if (row_r == FRAME_ROWS_I - ONE_D) begin
              state_nxt = S_FFLUSH;
            end else begin
              state_nxt = S_RUN;
              row_nxt   = row_r + ONE_D;
            end
          end
        end
      end
      S_FFLUSH: begin
        if (adv) begin
          col_nxt = col_r + ONE_D;
          if (col_r == cols_r - ONE_D) begin
            col_nxt   = '0;
            state_nxt = S_TAIL;
          end
        end
      end
      default: begin
        state_nxt = S_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r <= S_RUN;
      col_r   <= '0;
      row_r   <= '0;
      cols_r  <= '0;
      fl_r    <= '0;
      win0_r  <= '0;
      win1_r  <= '0;
    end else if (CE_I) begin
      state_r <= state_nxt;
      col_r   <= col_nxt;
      row_r   <= row_nxt;
      cols_r  <= cols_nxt;
      fl_r    <= fl_nxt;
      win0_r  <= win0_nxt;
      win1_r  <= win1_nxt;
    end
  end

  // line memories: a holds the previous row, b the one before; no reset needed
  always_ff @(posedge CLK_I) begin
    if (in_fire) begin
      mem_a[cur_col[AW-1:0]] <= S_TDATA_I;
      mem_b[cur_col[AW-1:0]] <= rd_a;
    end
  end

  // fixed-depth pipeline keeps the latency exact whenever nothing stalls
  always_comb begin
    for (int i = 0; i < PIPE_STAGES; i++) begin
      pv_nxt[i] = pv_r[i];
      pd_nxt[i] = pd_r[i];
      pm_nxt[i] = pm_r[i];
    end
    if (adv) begin
      pv_nxt[0] = emit;
      pd_nxt[0] = s0_pix;
      pm_nxt[0] = s0_meta;
      for (int i = 1; i < PIPE_STAGES; i++) begin
        pv_nxt[i] = pv_r[i-1];
        pd_nxt[i] = pd_r[i-1];
        pm_nxt[i] = pm_r[i-1];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    for (int i = 0; i < PIPE_STAGES; i++) begin
      if (RST_I) begin
        pv_r[i] <= 1'b0;
        pd_r[i] <= '0;
        pm_r[i] <= '0;
      end else if (CE_I) begin
        pv_r[i] <= pv_nxt[i];
        pd_r[i] <= pd_nxt[i];
        pm_r[i] <= pm_nxt[i];
      end
    end
  end

  // two-entry output buffer: absorbs a receiver stall without losing a word
  assign push = adv && pv_r[LAST];
  assign pop  = M_TVALID_O && M_TREADY_I;

  always_comb begin
    for (int i = 0; i < BUF_DEPTH; i++) begin
      bd_nxt[i] = bd_r[i];
      bm_nxt[i] = bm_r[i];
    end
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      bd_nxt[wp_r] = pd_r[LAST];
      bm_nxt[wp_r] = pm_r[LAST];
      wp_nxt       = !wp_r;
    end
    if (pop) begin
      rp_nxt = !rp_r;
    end
    cnt_nxt = cnt_r + CNTW'(push) - CNTW'(pop);
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        bd_r[i] <= '0;
        bm_r[i] <= '0;
      end
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= '0;
    end else if (CE_I) begin
      bd_r  <= bd_nxt;
      bm_r  <= bm_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // valid is gated by the enable so a frozen core never completes a handshake
  assign M_TVALID_O = CE_I && !RST_I && cnt_r != '0;
  assign M_TDATA_O  = bd_r[rp_r];
  assign M_TLAST_O  = bm_r[rp_r].last;
  assign M_TUSER_O  = bm_r[rp_r].user;

  // helper counts for the checks below
  logic [31:0] in_tot_r, out_tot_r;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      in_tot_r  <= '0;
      out_tot_r <= '0;
    end else begin
      in_tot_r  <= in_tot_r + 32'(in_fire);
      out_tot_r <= out_tot_r + 32'(pop);
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_latency;
    (adv && emit) ##1 adv [*8] ##1 adv [*8] |=> pv_r[LAST];
  endproperty
  a_latency: assert property (p_latency) else $error("pipeline depth wrong");

  property p_count;
    out_tot_r <= in_tot_r;
  endproperty
  a_count: assert property (p_count) else $error("more outputs than inputs");

  property p_drain;
    (cnt_r == CNTW'(1) && pop && !pv_r[LAST]) |=> !M_TVALID_O;
  endproperty
  a_drain: assert property (p_drain) else $error("valid without buffered data");

  property p_full;
    (cnt_r == BUF_FULL && pv_r[LAST]) |-> !S_TREADY_O && !push;
  endproperty
  a_full: assert property (p_full) else $error("input taken while buffering full");

  property p_lflush_entry;
    (in_fire && S_TLAST_I) |=> !S_TREADY_O [*8];
  endproperty
  a_lflush_entry: assert property (p_lflush_entry) else $error("ready rose early after line end");

  property p_lflush_len;
    (state_r == S_LFLUSH && state_nxt != S_LFLUSH && CE_I) |-> fl_r == FL_LAST && adv;
  endproperty
  a_lflush_len: assert property (p_lflush_len) else $error("line flush length wrong");

  property p_fflush_len;
    (state_r == S_FFLUSH && state_nxt == S_TAIL && CE_I) |-> col_r == cols_r - ONE_D && !S_TREADY_O;
  endproperty
  a_fflush_len: assert property (p_fflush_len) else $error("frame flush length wrong");

  property p_hold;
    (M_TVALID_O && !M_TREADY_I) ##1 CE_I |-> M_TVALID_O && $stable(M_TDATA_O) && $stable(M_TLAST_O);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed while stalled");

  property p_freeze;
    !CE_I |=> $stable(state_r) && $stable(col_r) && $stable(cnt_r) && $stable(pv_r[0]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  property p_bypass;
    (adv && emit && BYPASS_I && !TPG_I && HAS_BYPASS) |=> pd_r[0] == $past(ctr);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered the pixel");

  c_line_flush: cover property (in_fire && S_TLAST_I ##1 state_r == S_LFLUSH);
  c_frame_flush: cover property (state_r == S_FFLUSH ##[1:200] state_r == S_TAIL);
  c_buf_full: cover property (cnt_r == BUF_FULL && !M_TREADY_I);
  c_sof_out: cover property (pop && M_TUSER_O);
endmodule: edge_filter

// ### tb/video_sink_model.sv
/* video_sink_model: downstream video sink that stores every output beat of the filter.
   assumes: shares the filter clock; mode_i from the bench picks free, gappy or halted ready. */
`timescale 1ns/10ps
module video_sink_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [23:0] tdata_i,
  input  wire logic        tvalid_i,
  input  wire logic        tlast_i,
  input  wire logic        tuser_i,
  output logic             tready_o
);
  logic [23:0] beats[$];
  logic        lasts[$];
  logic        users[$];
  int          cyc = 0;
  int          first_cyc = 0;

  initial tready_o = 1'b0;

  // a beat counts only at a rising edge with valid and ready high
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (!rst_i && tvalid_i === 1'b1 && tready_o) begin
      if (beats.size() == 0) first_cyc = cyc;
      beats.push_back(tdata_i);
      lasts.push_back(tlast_i);
      users.push_back(tuser_i);
    end
  end

  // ready moves just after the edge; mode 1 stalls 3 of every 8 cycles, mode 2 halts
  always @(posedge clk_i) begin
    tready_o <= (mode_i == 2'd0) || (mode_i == 2'd1 && cyc[2:0] > 3'd2);
  end
endmodule: video_sink_model

// ### tb/edge_enhance_filter_test.sv
/* edge_enhance_filter_test: self-checking bench for the edge filter on 32x32 frames.
   assumes: DW of 8; the sink model stores output beats; bench drives the source side. */
`timescale 1ns/10ps
module edge_enhance_filter_test;
  import edge_pkg::*;
  localparam int COLS = 32;
  localparam int ROWS = 32;
  localparam int NPIX = COLS * ROWS;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             ce = 1'b1;
  logic [23:0]      s_data = '0;
  logic             s_valid = 1'b0;
  logic             s_last = 1'b0;
  logic             s_user = 1'b0;
  logic             s_ready;
  logic [23:0]      m_data;
  logic             m_valid;
  logic             m_last;
  logic             m_user;
  logic             m_ready;
  logic [7:0]       g_sob = '0;
  logic [7:0]       g_lap = '0;
  logic             byp = 1'b1;
  logic             tpg = 1'b0;
  logic [DIM_W-1:0] rows = DIM_W'(ROWS);
  logic [1:0]       mode = 2'd0;
  int               fails = 0;
  int               checks_done = 0;
  int               last_take = 0;
  int               in_first = 0;
  bit               timing = 0;

  always #20 clk = ~clk;

  edge_filter #(.DW(8), .MAX_COLS(COLS)) DUT (
    .CLK_I(clk), .RST_I(rst), .CE_I(ce), .S_TDATA_I(s_data), .S_TVALID_I(s_valid),
    .S_TLAST_I(s_last), .S_TUSER_I(s_user), .S_TREADY_O(s_ready), .M_TDATA_O(m_data),
    .M_TVALID_O(m_valid), .M_TLAST_O(m_last), .M_TUSER_O(m_user), .M_TREADY_I(m_ready),
    .SOBEL_GAIN_I(g_sob), .LAPLACE_GAIN_I(g_lap), .BYPASS_I(byp), .TPG_I(tpg), .FRAME_ROWS_I(rows));

  video_sink_model sink (.clk_i(clk), .rst_i(rst), .mode_i(mode), .tdata_i(m_data),
    .tvalid_i(m_valid), .tlast_i(m_last), .tuser_i(m_user), .tready_o(m_ready));

  task automatic close_out;
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask: close_out

  task automatic chk_pix(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected pixel at %0t: got %h expected %h", $time, got, exp);
    end
  endtask: chk_pix

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask: chk_bit

  task automatic chk_num(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      fails++;
      $display("unexpected count at %0t: got %h expected %h", $time, got, exp);
    end
  endtask: chk_num

  // step image in luma at column 16; chroma carries row and column so moves show up
  function automatic logic [23:0] pix(input int r, input int c, input logic [7:0] lo, input logic [7:0] hi);
    return {8'(c), 8'(r), (c < 16) ? lo : hi};
  endfunction: pix

  // one frame; gaps drops valid mid-line, pauses 40 cycles in row 4 and gates ce in row 10
  task automatic send_frame(input logic [7:0] lo, input logic [7:0] hi, input bit gaps);
    int n;
    for (int r = 0; r < ROWS; r++) begin
      for (int c = 0; c < COLS; c++) begin
        if (gaps && c == 5) begin
          s_valid <= 1'b0;
          ce <= (r != 10);
          repeat ((r == 4) ? 40 : 3) @(posedge clk);
          if (r == 4) chk_bit(m_valid, 1'b0);
          if (r == 10) chk_bit(s_ready | m_valid, 1'b0);
          ce <= 1'b1;
        end
        s_valid <= 1'b1;
        s_data <= pix(r, c, lo, hi);
        s_last <= (c == COLS - 1);
        s_user <= (r == 0 && c == 0);
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (s_ready !== 1'b1 && n < 500);
        if (s_ready !== 1'b1) chk_bit(s_ready, 1'b1);
        if (timing && last_take < 0) in_first = sink.cyc;
        if (timing && last_take >= 0) chk_num(sink.cyc - last_take, (c > 0) ? 1 : (r > 0) ? 20 : COLS + 39);
        last_take = sink.cyc;
      end
    end
    s_valid <= 1'b0;
    s_last <= 1'b0;
    // one idle edge, so a following frame never drives valid twice in one step
    @(posedge clk);
  endtask: send_frame

  // waits, bounded, until the sink holds the expected number of beats
  task automatic drain(input int target);
    for (int n = 0; n < 4000 && sink.beats.size() < target; n++) @(posedge clk);
    repeat (30) @(posedge clk);
    chk_num(sink.beats.size(), target);
  endtask: drain

  // kind 0 exact copy, 1 ramp of the column counter (next column, wraps at line end),
  // 2 enhanced edge around column 16
  task automatic check_frame(input int kind, input logic [7:0] lo, input logic [7:0] hi, input int b);
    int r;
    int c;
    logic [23:0] got;
    logic [23:0] exp;
    for (int i = 0; i < NPIX; i++) begin
      r = i / COLS;
      c = i % COLS;
      got = sink.beats[b + i];
      exp = pix(r, c, lo, hi);
      chk_bit(sink.users[b + i], i == 0);
      chk_bit(sink.lasts[b + i], c == COLS - 1);
      if (kind == 1) chk_pix(got, {3{8'((c + 1) % COLS)}});
      else if (kind == 0 || c < 15 || c > 16) chk_pix(got, exp);
      else chk_pix({got[23:8], 8'h00}, {exp[23:8], 8'h00});
      if (kind == 2 && c == 16) chk_bit((hi == 8'hff) ? got[7:0] == 8'hff : got[7:0] > hi, 1'b1);
    end
  endtask: check_frame

  // two frames back to back with a free sink: latency, spacing and bypass copy
  task automatic t_stream;
    timing = 1;
    last_take = -1;
    send_frame(8'h20, 8'h90, 0);
    send_frame(8'h20, 8'h90, 0);
    timing = 0;
    drain(2 * NPIX);
    chk_num(sink.first_cyc - in_first, COLS + LINE_FLUSH_CYC + LATENCY_CYC);
    check_frame(0, 8'h20, 8'h90, 0);
    check_frame(0, 8'h20, 8'h90, NPIX);
  endtask: t_stream

  // test pattern wins over bypass
  task automatic t_tpg;
    int b;
    b = sink.beats.size();
    tpg <= 1'b1;
    send_frame(8'h00, 8'h00, 0);
    drain(b + NPIX);
    check_frame(1, 8'h00, 8'h00, b);
    tpg <= 1'b0;
  endtask: t_tpg

  // zero gain leaves the image alone, unit gain lifts the edge, huge gain must clamp
  task automatic t_gain;
    logic [7:0] gt[3] = '{8'h00, 8'h10, 8'hff};
    logic [7:0] lo[3] = '{8'h40, 8'h40, 8'h00};
    logic [7:0] hi[3] = '{8'h80, 8'h80, 8'hff};
    int b;
    byp <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      b = sink.beats.size();
      g_sob <= gt[k];
      g_lap <= gt[k];
      send_frame(lo[k], hi[k], 0);
      drain(b + NPIX);
      check_frame((k == 0) ? 0 : 2, lo[k], hi[k], b);
    end
    byp <= 1'b1;
  endtask: t_gain

  // gappy sink plus a 64-cycle halt: input must back off and lose nothing
  task automatic t_stall;
    int b;
    b = sink.beats.size();
    mode <= 2'd1;
    fork
      send_frame(8'h11, 8'h77, 0);
      begin
        repeat (300) @(posedge clk);
        mode <= 2'd2;
        repeat (64) @(posedge clk);
        chk_bit(s_ready, 1'b0);
        chk_bit(m_valid, 1'b1);
        mode <= 2'd1;
      end
    join
    drain(b + NPIX);
    check_frame(0, 8'h11, 8'h77, b);
    mode <= 2'd0;
  endtask: t_stall

  // source pauses and clock-enable gaps
  task automatic t_gaps;
    int b;
    b = sink.beats.size();
    send_frame(8'h33, 8'hcc, 1);
    drain(b + NPIX);
    check_frame(0, 8'h33, 8'hcc, b);
  endtask: t_gaps

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit(s_ready, 1'b1);
    chk_bit(m_valid, 1'b0);
    t_stream;
    t_tpg;
    t_gain;
    t_stall;
    t_gaps;
    close_out;
  end

  // about 14k cycles expected; a generous margin before calling it a hang
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    close_out;
  end
endmodule: edge_enhance_filter_test
